// ==== core/scg_sleep_clock_gate.sv ====
// Purpose: Sleep-mode unit clock gating register with run and deep-sleep siblings
// Assumes: Classic Wishbone slave on mclk at 200 MHz; power mode from the power controller
// Notes: Unit access requests are checked against the effective gate and faulted when unclocked
`timescale 1ns/100ps
`default_nettype none
`include "scg_regs.svh"
module scg_sleep_clock_gate
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [1:0] power_mode,
    input wire logic unit_req,
    input wire logic [2:0] unit_sel,
    output logic unit_ok,
    output logic unit_fault,
    output logic [31:0] unit_clock_enable,
    output logic irq
);
    logic [31:0] run_unit_clock_gate_1;
    logic [31:0] sleep_unit_clock_gate_1;
    logic [31:0] deepsleep_unit_clock_gate_1;
    logic [31:0] run_clock_config;
    logic [31:0] effective_gate;
    logic [1:0] fault_status;
    logic [1:0] fault_mask;
    logic [2:0] fault_unit;
    logic bus_busy;
    logic wb_req;
    logic wr_strobe;
    logic [31:0] next_dat;
    logic unit_on;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_config;
    logic wr_status;
    logic wr_mask;
    logic rd_strobe;
    scg_bus_t bus_state;
    scg_bus_t next_bus_state;
    logic [1:0] fault_set;
    logic [1:0] fault_clear;
    logic [1:0] next_fault_status;
    logic [`SCG_UNIT_COUNT-1:0] unit_hit;
    logic [`SCG_UNIT_COUNT-1:0] unit_gate_vec;

    // ============================================================
    // Helpers
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
        input logic [3:0] sel, input logic [31:0] keep);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & keep;
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [4:0] unit_bit(input logic [2:0] sel);
        case (sel)
            3'h0: unit_bit = 5'h00;
            3'h1: unit_bit = 5'h01;
            3'h2: unit_bit = 5'h04;
            3'h3: unit_bit = 5'h0C;
            3'h4: unit_bit = 5'h10;
            3'h5: unit_bit = 5'h11;
            3'h6: unit_bit = 5'h12;
            default: unit_bit = 5'h18;
        endcase
    endfunction

    // Every write decode goes through this; the read mux matches wb_adr_i in its own case
    function automatic logic addr_hit(input logic [11:0] adr, input logic [11:0] off);
        return adr == off;
    endfunction

    // ============================================================
    // Bus handshake
    // One wait-free answer per request; ack drops the cycle after it is given
    assign wb_req = wb_cyc_i && wb_stb_i && !bus_busy;
    assign wr_strobe = wb_req && wb_we_i;
    assign rd_strobe = wb_req && !wb_we_i;

    // A held request is taken again after the answer state, which blocks a second take for one cycle only
    always_comb
    begin
        case (bus_state)
            SCG_BUS_IDLE: next_bus_state = (wb_cyc_i && wb_stb_i) ? SCG_BUS_ACK : SCG_BUS_IDLE;
            SCG_BUS_ACK: next_bus_state = SCG_BUS_IDLE;
            default: next_bus_state = SCG_BUS_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_state <= SCG_BUS_IDLE;
        end
        else
        begin
            bus_state <= next_bus_state;
        end
    end

    assign bus_busy = (bus_state == SCG_BUS_ACK);

    // ============================================================
    // Address decode
    assign wr_run = wr_strobe && addr_hit(wb_adr_i, `SCG_OFF_RUN_GATE);
    assign wr_sleep = wr_strobe && addr_hit(wb_adr_i, `SCG_OFF_SLEEP_GATE);
    assign wr_deep = wr_strobe && addr_hit(wb_adr_i, `SCG_OFF_DEEP_GATE);
    assign wr_config = wr_strobe && addr_hit(wb_adr_i, `SCG_OFF_RUN_CLOCK_CONFIG);
    assign wr_status = wr_strobe && addr_hit(wb_adr_i, `SCG_OFF_FAULT_STATUS);
    assign wr_mask = wr_strobe && addr_hit(wb_adr_i, `SCG_OFF_FAULT_MASK);

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= wb_req;
        end
    end

    assign wb_err_o = 1'b0;

    // ============================================================
    // Gating registers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_unit_clock_gate_1 <= `SCG_GATE_RESET;
        end
        else if (wr_sleep)
        begin
            sleep_unit_clock_gate_1 <= merge_bytes(sleep_unit_clock_gate_1, wb_dat_i, wb_sel_i,
                `SCG_GATE_MASK);
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            run_unit_clock_gate_1 <= `SCG_GATE_RESET;
        end
        else if (wr_run)
        begin
            run_unit_clock_gate_1 <= merge_bytes(run_unit_clock_gate_1, wb_dat_i, wb_sel_i,
                `SCG_GATE_MASK);
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            deepsleep_unit_clock_gate_1 <= `SCG_GATE_RESET;
        end
        else if (wr_deep)
        begin
            deepsleep_unit_clock_gate_1 <= merge_bytes(deepsleep_unit_clock_gate_1, wb_dat_i, wb_sel_i,
                `SCG_GATE_MASK);
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            run_clock_config <= `SCG_CONFIG_RESET;
        end
        else if (wr_config)
        begin
            // Only the automatic gating select is kept; the rest of this word belongs elsewhere
            run_clock_config <= merge_bytes(run_clock_config, wb_dat_i, wb_sel_i,
                32'h1 << `SCG_AUTO_GATING_BIT);
        end
    end

    // ============================================================
    // Effective gate
    scg_unit_gate u_gate
    (
        .mclk(mclk),
        .nrst(nrst),
        .mode(power_mode),
        .auto_gating_select(run_clock_config[`SCG_AUTO_GATING_BIT]),
        .run_gate(run_unit_clock_gate_1),
        .sleep_gate(sleep_unit_clock_gate_1),
        .deep_gate(deepsleep_unit_clock_gate_1),
        .effective_gate(effective_gate)
    );

    assign unit_clock_enable = effective_gate;

    // ============================================================
    // Unit access check
    // Software must enable a unit first; otherwise the access faults
    // One lane per unit; all 8 unit_sel codes are taken, so a further unit also needs a wider unit_sel besides the bit table
    genvar gi;
    generate
        for (gi = 0; gi < `SCG_UNIT_COUNT; gi++)
        begin : g_unit
            assign unit_hit[gi] = (int'(unit_sel) == gi);
            assign unit_gate_vec[gi] = effective_gate[unit_bit(3'(gi))];
        end
    endgenerate

    assign unit_on = |(unit_hit & unit_gate_vec);
    assign unit_ok = unit_req && unit_on;
    assign unit_fault = unit_req && !unit_on;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_unit <= 3'h0;
        end
        else if (unit_fault)
        begin
            fault_unit <= unit_sel;
        end
    end

    // ============================================================
    // Interrupt status; a new fault wins over a clear in the same cycle
    always_comb
    begin
        fault_clear = 2'h0;
        if (wr_status && wb_sel_i[0])
        begin
            fault_clear = wb_dat_i[1:0];
        end
        fault_set = {unit_fault && fault_status[0], unit_fault};
        next_fault_status = (fault_status & ~fault_clear) | fault_set;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_status <= 2'h0;
        end
        else
        begin
            fault_status <= next_fault_status;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_mask <= 2'h0;
        end
        else if (wr_mask && wb_sel_i[0])
        begin
            fault_mask <= wb_dat_i[1:0];
        end
    end

    assign irq = |(fault_status & fault_mask);

    // ============================================================
    // Read data
    always_comb
    begin
        case (wb_adr_i)
            `SCG_OFF_SLEEP_GATE: next_dat = sleep_unit_clock_gate_1;
            `SCG_OFF_RUN_GATE: next_dat = run_unit_clock_gate_1;
            `SCG_OFF_DEEP_GATE: next_dat = deepsleep_unit_clock_gate_1;
            `SCG_OFF_RUN_CLOCK_CONFIG: next_dat = run_clock_config;
            `SCG_OFF_FAULT_STATUS: next_dat = {30'h0, fault_status};
            `SCG_OFF_FAULT_MASK: next_dat = {30'h0, fault_mask};
            `SCG_OFF_FAULT_UNIT: next_dat = {29'h0, fault_unit};
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (rd_strobe)
        begin
            wb_dat_o <= next_dat;
        end
    end
endmodule // scg_sleep_clock_gate
`default_nettype wire

// ==== core/scg_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the sleep clock gate block
// Assumes: Included by bare name from the package, the top module and the unit gate module
// Notes: Byte addresses on a 32-bit classic Wishbone slave
//
// Behaviour
// - A set gating bit clocks its unit; a clear bit stops and disables it.
// - Access to a unit whose clock is gated off answers with a bus fault.
// - Reset clears every gating bit, leaving all units unclocked.
// - Run, sleep and deep-sleep gating registers share one bit layout.
// - Sleep register applies only while automatic gating select is set.
// - Sleep register at 0x114, reset zero, gating bits 24,18,17,16,12,4,1,0.
// - Unimplemented bits read zero and ignore writes; software preserves them.
`ifndef SCG_REGS_SVH
`define SCG_REGS_SVH

// ============================================================
// Offsets
`define SCG_OFF_RUN_CLOCK_CONFIG 12'h060
`define SCG_OFF_RUN_GATE 12'h104
`define SCG_OFF_SLEEP_GATE 12'h114
`define SCG_OFF_DEEP_GATE 12'h124
`define SCG_OFF_FAULT_STATUS 12'h200
`define SCG_OFF_FAULT_MASK 12'h204
`define SCG_OFF_FAULT_UNIT 12'h208

// ============================================================
// Fields
`define SCG_GATE_MASK 32'h0107_1013
`define SCG_GATE_RESET 32'h0000_0000
`define SCG_CONFIG_RESET 32'h0000_0000
`define SCG_AUTO_GATING_BIT 27
`define SCG_EVT_FAULT_BIT 0
`define SCG_EVT_WIDTH 2
`define SCG_EVT_MASK 32'h0000_0003
`define SCG_UNIT_COUNT 8
`define SCG_UNIT_SEL_W 3

`endif

// ==== core/scg_pkg.sv ====
// Purpose: Types of the sleep clock gate block
// Assumes: scg_regs.svh present on the include path
// Notes: Power mode encoding is Gray along run, sleep, deep sleep
package scg_pkg;
    `include "scg_regs.svh"

    typedef enum logic [1:0]
    {
        SCG_MODE_RUN = 2'h0,
        SCG_MODE_SLEEP = 2'h1,
        SCG_MODE_DEEP = 2'h3
    } scg_mode_t;

    typedef enum logic [1:0]
    {
        SCG_BUS_IDLE = 2'h0,
        SCG_BUS_ACK = 2'h1
    } scg_bus_t;
endpackage

// ==== core/scg_unit_gate.sv ====
// Purpose: Selects the effective gating word for the present power mode
// Assumes: Inputs and outputs on mclk
// Notes: Output is registered so that enables never glitch
`timescale 1ns/100ps
`default_nettype none
`include "scg_regs.svh"
module scg_unit_gate
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [1:0] mode,
    input wire logic auto_gating_select,
    input wire logic [31:0] run_gate,
    input wire logic [31:0] sleep_gate,
    input wire logic [31:0] deep_gate,
    output logic [31:0] effective_gate
);
    logic [31:0] next_effective_gate;

    // ============================================================
    // Selection
    always_comb
    begin
        case (scg_mode_t'(mode))
            SCG_MODE_SLEEP: next_effective_gate = auto_gating_select ? sleep_gate : run_gate;
            SCG_MODE_DEEP: next_effective_gate = auto_gating_select ? deep_gate : run_gate;
            default: next_effective_gate = run_gate;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            effective_gate <= `SCG_GATE_RESET;
        else
            effective_gate <= next_effective_gate & `SCG_GATE_MASK;
    end
endmodule // scg_unit_gate
`default_nettype wire

// ==== bench/scg_checker_sva.sv ====
// Purpose: Port assertions for the sleep clock gate
// Assumes: Bound to the top module
// Notes: Unit bit order follows unit_sel
`timescale 1ns/100ps
`default_nettype none
module scg_checker
    import scg_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] power_mode,
    input wire logic unit_req,
    input wire logic [2:0] unit_sel,
    input wire logic unit_ok,
    input wire logic unit_fault,
    input wire logic [31:0] unit_clock_enable
);
    // ====================
    // Checks
    localparam int UB [8] = '{0, 1, 4, 12, 16, 17, 18, 24};
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence take_s;
        $rose(wb_cyc_i && wb_stb_i);
    endsequence
    gate_bits_a: assert property ((unit_clock_enable & ~32'h0107_1013) == 32'h0) else $error("gate bit");
    unit_map_a: assert property (unit_req |-> unit_ok == unit_clock_enable[UB[unit_sel]]) else $error("unit");
    fault_map_a: assert property (unit_req |-> unit_fault != unit_ok) else $error("fault");
    no_fault_a: assert property (!unit_req |-> !unit_fault && !unit_ok) else $error("idle");
    reset_zero_a: assert property ($rose(nrst) |-> unit_clock_enable == 32'h0) else $error("reset");
    ack_once_a: assert property (take_s |=> wb_ack_o ##1 !wb_ack_o) else $error("ack");
    rsvd_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h114 |->
        (wb_dat_o & ~32'h0107_1013) == 32'h0) else $error("reserved");
    // A sleep write must not move the gate outside sleep mode
    sleep_idle_a: assert property ((wb_we_i && wb_adr_i == 12'h114 && power_mode != 2'h1
        && $stable(power_mode)) ##0 take_s |=> $stable(unit_clock_enable)) else $error("sleep write");
endmodule // scg_checker
bind scg_sleep_clock_gate scg_checker u_chk
(
    .mclk(mclk),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .power_mode(power_mode),
    .unit_req(unit_req),
    .unit_sel(unit_sel),
    .unit_ok(unit_ok),
    .unit_fault(unit_fault),
    .unit_clock_enable(unit_clock_enable)
);
`default_nettype wire

// ==== bench/scg_unit_model.sv ====
// Purpose: Peripheral access model on the unit port
// Assumes: Same clock as the gate block
// Notes: Select is scrambled when idle
`timescale 1ns/100ps
`default_nettype none
module scg_unit_model
(
    input wire logic mclk,
    output logic unit_req,
    output logic [2:0] unit_sel,
    input wire logic unit_ok,
    input wire logic unit_fault
);
    initial
    begin
        unit_req = 1'b0;
        unit_sel = 3'h0;
    end
    task automatic touch(input logic [2:0] s, output logic ok);
        @(posedge mclk);
        unit_req <= 1'b1;
        unit_sel <= s;
        @(posedge mclk);
        ok = unit_ok && !unit_fault;
        unit_req <= 1'b0;
        unit_sel <= ~s;
    endtask
endmodule // scg_unit_model
`default_nettype wire

// ==== bench/scg_sleep_clock_gate_tb.sv ====
// Purpose: Self-checking bench for the sleep clock gate
// Assumes: Unit model drives the unit port
// Notes: Byte lanes held at all ones except for one top-lane write in t_layout
`timescale 1ns/100ps
`default_nettype none
module scg_sleep_clock_gate_tb
    import scg_pkg::*;
();
    logic mclk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, unit_req, unit_ok, unit_fault, irq, ok, qe;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i, wb_dat_o, unit_clock_enable, q;
    logic [1:0] power_mode;
    logic [2:0] unit_sel;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int ub [8] = '{0, 1, 4, 12, 16, 17, 18, 24};
    scg_sleep_clock_gate dut
    (
        .mclk(mclk),
        .nrst(nrst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .power_mode(power_mode),
        .unit_req(unit_req),
        .unit_sel(unit_sel),
        .unit_ok(unit_ok),
        .unit_fault(unit_fault),
        .unit_clock_enable(unit_clock_enable),
        .irq(irq)
    );
    scg_unit_model model
    (
        .mclk(mclk),
        .unit_req(unit_req),
        .unit_sel(unit_sel),
        .unit_ok(unit_ok),
        .unit_fault(unit_fault)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1)
            @(posedge mclk);
        q = wb_dat_o;
        qe = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic t_layout();
        chk(unit_clock_enable, 32'h0);
        wb(0, 12'h114, 0);
        chk(q, 32'h0);
        wb(1, 12'h114, 32'hFFFF_FFFF);
        wb(0, 12'h114, 0);
        chk(q, 32'h0107_1013);
        // Only the top byte lane is written, so only the comparator bit may clear
        wb_sel_i <= 4'h8;
        wb(1, 12'h114, 32'h0);
        wb_sel_i <= 4'hF;
        wb(0, 12'h114, 0);
        chk(q, 32'h0007_1013);
        wb(0, 12'h3F0, 0);
        chk(q, 32'h0);
        chk(qe, 0);
    endtask
    task automatic t_units();
        for (int u = 0; u < 8; u++)
        begin
            wb(1, 12'h104, 32'h1 << ub[u]);
            repeat (2) @(posedge mclk);
            chk(unit_clock_enable, 32'h1 << ub[u]);
            model.touch(3'(u), ok);
            chk(ok, 1);
            model.touch(3'(u ^ 1), ok);
            chk(ok, 0);
        end
        wb(0, 12'h208, 0);
        chk(q, 32'h6);
        wb(0, 12'h200, 0);
        chk(q, 32'h3);
        chk(irq, 0);
        wb(1, 12'h204, 32'h1);
        chk(irq, 1);
        wb(1, 12'h200, 32'h3);
        chk(irq, 0);
        wb(0, 12'h200, 0);
        chk(q, 32'h0);
    endtask
    task automatic t_modes();
        wb(1, 12'h104, 32'h1);
        wb(1, 12'h114, 32'h10);
        wb(1, 12'h124, 32'h1000);
        power_mode <= SCG_MODE_SLEEP;
        repeat (3) @(posedge mclk);
        chk(unit_clock_enable, 32'h1);
        wb(1, 12'h060, 32'h0800_0000);
        repeat (2) @(posedge mclk);
        chk(unit_clock_enable, 32'h10);
        power_mode <= SCG_MODE_DEEP;
        repeat (3) @(posedge mclk);
        chk(unit_clock_enable, 32'h1000);
        // The unused mode code falls back to the run register
        power_mode <= 2'h2;
        repeat (3) @(posedge mclk);
        chk(unit_clock_enable, 32'h1);
        power_mode <= SCG_MODE_RUN;
        repeat (3) @(posedge mclk);
        chk(unit_clock_enable, 32'h1);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Hang guard, far above the fewer than 150 cycles used
    always @(posedge mclk)
    begin
        if (++cycles == 3000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h0;
        wb_dat_i = 32'h0;
        power_mode = SCG_MODE_RUN;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        t_layout();
        t_units();
        t_modes();
        print_verdict();
    end
endmodule // scg_sleep_clock_gate_tb
`default_nettype wire
